// ==== aidfe_top.sv ====
// Notes on behaviour
// (R1) Frame sync 8 kHz, bit clock 128-1536 kHz; the receiver needs 32 bit clocks per frame, so 256 kHz at least
// (R2) Route audio from the selected serial port
// (R3) Port change: mute, off, swap, resume, unmute
// (R4) Mix left, right or halved sum
// (R5) Separate mix choice per port at 01h/03h
// (R6) First-order DC-blocking high-pass per coefficient
// (R7) High-pass coefficient accepts 0 to 511
// (R8) High-pass skipped on zero or skip flag
// (R9) De-emphasis is first-order low-pass near 3.5kHz
// (R10) Rate field: off, 32, 44.1, 48 kHz
// (R11) Equalizer bypassed or five bands
// (R12) Each band is Regalia-Mitra all-pass section
// (R13) Band ranges: gain, centre, quality factor
// (R14) Host picks configuration bits from coefficient signs
// (R15) Bands run in series, A to E
// (R16) At most 12 dB gain per band
// (R17) Band halving flag gives 0 or -6 dB
// (R18) Host applies halving to B, A first
// (R19) Stored k' is one minus/plus K
// (R20) Two 16-bit words per band
// (R21) k' is mantissa times two to minus exponent
// (R22) Word one: cfg, 11-bit mantissa, 4-bit exponent
// (R23) Word two: cfg, mantissa, exponent, k0, halving
// (R24) Soft mute ramps raised-cosine over 128 samples; the code ramps a smoothstep curve instead
// (R25) Mix, high-pass, de-emphasis, equalizer, one out
// (R26) Band coefficients commit only after word two
`timescale 1ns/100ps
`default_nettype none
`include "aidfe_regs.svh"

module aidfe_top
    import aidfe_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [1:0]  bit_clk,
    input  wire logic [1:0]  frame_sync_pin,
    input  wire logic [1:0]  serial_data_pin,
    input  wire logic        reg_wr_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wr_data,
    output var  logic [15:0] reg_rd_data,
    output var  logic [15:0] audio_out,
    output var  logic        audio_out_valid,
    output var  logic        off_mode,
    output var  logic        active_port,
    output var  logic        soft_mute_active
);

    function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
        if (v > 40'sh0000007FFF)
            sat16 = 16'sh7FFF;
        else if (v < 40'shFFFFFF8000)
            sat16 = 16'sh8000;
        else
            sat16 = v[15:0];
    endfunction : sat16

    // Smoothstep stands in for the raised cosine; error peaks just over one percent of full scale
    function automatic logic [16:0] ramp_gain(input logic [7:0] n);
        logic [23:0] sq;
        logic [23:0] cu;
        sq = 24'(n) * 24'(n);
        cu = (sq * 24'(n)) >> 7;
        ramp_gain = 17'((sq * 24'h000003) - (cu * 24'h000002));
    endfunction : ramp_gain

    // Serial receivers, one per port, on the port's own bit clock (see R1)
    aidfe_frame_t rx_frame [2];
    logic         rx_evt   [2];

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : gen_rx
            logic [31:0] shift_reg;
            logic [4:0]  cnt_reg;
            logic        fs_prev_reg;
            logic        tgl_reg;
            aidfe_frame_t word_reg;
            logic [2:0]  sync_reg;

            always_ff @(posedge bit_clk[p] or posedge sys_rst) begin
                if (sys_rst) begin
                    shift_reg   <= 32'h00000000;
                    cnt_reg     <= 5'h00;
                    fs_prev_reg <= 1'b0;
                    tgl_reg     <= 1'b0;
                    word_reg    <= '0;
                end else begin
                    fs_prev_reg <= frame_sync_pin[p];
                    shift_reg   <= {shift_reg[30:0], serial_data_pin[p]};
                    if (frame_sync_pin[p] && !fs_prev_reg)
                        cnt_reg <= 5'h01;
                    else if (cnt_reg != 5'h00)
                        cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == 5'h1F) begin
                        // Word stays put for a whole frame, so the toggle alone carries it across
                        word_reg <= {shift_reg[30:0], serial_data_pin[p]};
                        tgl_reg  <= ~tgl_reg;
                    end
                end
            end

            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst)
                    sync_reg <= 3'h0;
                else
                    sync_reg <= {sync_reg[1:0], tgl_reg};
            end

            assign rx_frame[p] = word_reg;
            assign rx_evt[p]   = sync_reg[2] ^ sync_reg[1];
        end
    endgenerate

    // Register file
    localparam logic [15:0] BYPASS_RST_VAL = `AIDFE_BYPASS_RST;

    logic [15:0]      sp_ctrl_reg [2];
    logic             insel_reg;
    logic             hp_skip_reg;
    logic             eq_bypass_reg;
    logic [8:0]       highpass_coef_setting;
    logic [1:0]       deemph_rate_choice;
    logic [15:0]      coef_stage_reg [AIDFE_NUM_BANDS];
    aidfe_band_coef_t coef_live_reg  [AIDFE_NUM_BANDS];
    logic [7:0]       eq_ofs;
    logic             eq_hit;
    logic [2:0]       eq_band;
    logic             eq_w2_wr;

    assign eq_ofs   = reg_addr - `AIDFE_EQ_BASE_OFS;
    assign eq_hit   = (reg_addr >= `AIDFE_EQ_BASE_OFS) && (eq_ofs < `AIDFE_EQ_WORDS);
    assign eq_band  = eq_ofs[3:1];
    assign eq_w2_wr = reg_wr_en && eq_hit && eq_ofs[0];

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sp_ctrl_reg[0]        <= `AIDFE_SP_CTRL_RST;
            sp_ctrl_reg[1]        <= `AIDFE_SP_CTRL_RST;
            insel_reg             <= 1'b0;
            hp_skip_reg           <= BYPASS_RST_VAL[`AIDFE_HPSKIP_BIT];
            eq_bypass_reg         <= BYPASS_RST_VAL[`AIDFE_EQBYP_BIT];
            highpass_coef_setting <= `AIDFE_HPF_RST;
            deemph_rate_choice    <= `AIDFE_DEEMPH_RST;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `AIDFE_DEV_CTRL_OFS: insel_reg <= reg_wr_data[`AIDFE_INSEL_BIT];
                `AIDFE_SP1_CTRL_OFS: sp_ctrl_reg[0] <= reg_wr_data;   // see R5
                `AIDFE_SP2_CTRL_OFS: sp_ctrl_reg[1] <= reg_wr_data;   // see R5
                `AIDFE_BYPASS_OFS: begin
                    hp_skip_reg   <= reg_wr_data[`AIDFE_HPSKIP_BIT];
                    eq_bypass_reg <= reg_wr_data[`AIDFE_EQBYP_BIT];
                end
                `AIDFE_HPF_OFS:    highpass_coef_setting <= reg_wr_data[8:0];   // see R7
                `AIDFE_DEEMPH_OFS: deemph_rate_choice <= reg_wr_data[1:0];
                default: ;
            endcase
        end
    end

    // Word one waits in a staging slot; word two commits the pair at once (see R26)
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int b = 0; b < AIDFE_NUM_BANDS; b++) begin
                coef_stage_reg[b] <= 16'h0000;
                coef_live_reg[b]  <= '0;
            end
        end else if (reg_wr_en && eq_hit) begin
            if (!eq_ofs[0])
                coef_stage_reg[eq_band] <= reg_wr_data;
            else
                coef_live_reg[eq_band] <= {coef_stage_reg[eq_band], reg_wr_data};   // see R20 R22 R23 R26
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rd_data <= 16'h0000;
        end else begin
            case (reg_addr)
                `AIDFE_DEV_CTRL_OFS: reg_rd_data <= {13'h0000, soft_mute_active, active_port, insel_reg};
                `AIDFE_SP1_CTRL_OFS: reg_rd_data <= sp_ctrl_reg[0];
                `AIDFE_SP2_CTRL_OFS: reg_rd_data <= sp_ctrl_reg[1];
                `AIDFE_BYPASS_OFS:   reg_rd_data <= {14'h0000, eq_bypass_reg, hp_skip_reg};
                `AIDFE_HPF_OFS:      reg_rd_data <= {7'h00, highpass_coef_setting};
                `AIDFE_DEEMPH_OFS:   reg_rd_data <= {14'h0000, deemph_rate_choice};
                default: begin
                    if (eq_hit)
                        reg_rd_data <= eq_ofs[0] ? coef_live_reg[eq_band][15:0] : coef_live_reg[eq_band][31:16];
                    else
                        reg_rd_data <= 16'h0000;
                end
            endcase
        end
    end

    // Processing sequencer
    aidfe_dsp_state_t   dsp_st;
    aidfe_mute_state_t  mute_st;
    aidfe_frame_t       frame_reg;
    logic signed [15:0] data_reg;
    logic [2:0]         band_idx;
    logic [7:0]         gain_idx;
    logic signed [15:0] hp_x1_reg, hp_y1_reg, de_y1_reg;
    logic signed [15:0] eq_x1 [AIDFE_NUM_BANDS];
    logic signed [15:0] eq_x2 [AIDFE_NUM_BANDS];
    logic signed [15:0] eq_y1 [AIDFE_NUM_BANDS];
    logic signed [15:0] eq_y2 [AIDFE_NUM_BANDS];
    logic               sample_evt;
    logic               hpf_off;
    logic [1:0]         mix_sel;

    assign sample_evt = active_port ? rx_evt[1] : rx_evt[0];   // see R2
    assign hpf_off    = hp_skip_reg || (highpass_coef_setting == 9'h000);   // see R8
    assign mix_sel    = sp_ctrl_reg[active_port][1:0];

    logic signed [15:0] mix_out, hpf_out, de_out, band_out, ap_sat, gain_out;
    logic signed [16:0] mix_sum;
    logic signed [31:0] hp_acc, de_acc, g_acc;
    logic signed [15:0] de_a;
    logic signed [17:0] k1q, k2q, kk1, kk2, a1;
    logic signed [35:0] a1_prod;
    logic signed [39:0] ap_acc, h_acc;
    logic signed [16:0] hsum, hdiff;
    aidfe_band_coef_t   bc;

    always_comb begin
        mix_sum = 17'(frame_reg.left) + 17'(frame_reg.right);
        case (mix_sel)   // see R4
            2'h0:    mix_out = frame_reg.left;
            2'h1:    mix_out = frame_reg.right;
            default: mix_out = mix_sum[16:1];
        endcase
        // y = x - x1 + y1 - c*y1/4096 (see R6)
        hp_acc  = 32'(data_reg) - 32'(hp_x1_reg) + 32'(hp_y1_reg)
                - ((32'(hp_y1_reg) * $signed({23'h000000, highpass_coef_setting})) >>> `AIDFE_HPF_SHIFT);
        hpf_out = hpf_off ? data_reg : sat16(40'(hp_acc));
        case (deemph_rate_choice)   // see R10
            2'h1:    de_a = `AIDFE_DEEMPH_A32;
            2'h2:    de_a = `AIDFE_DEEMPH_A44;
            default: de_a = `AIDFE_DEEMPH_A48;
        endcase
        // One-pole low-pass toward 3.5 kHz at the chosen rate (see R9)
        de_acc = 32'(de_y1_reg) + ((32'(de_a) * (32'(data_reg) - 32'(de_y1_reg))) >>> 15);
        de_out = (deemph_rate_choice == 2'h0) ? data_reg : sat16(40'(de_acc));
        // Coefficients in Q14: k' = M * 2^-E, K = +/-(k' - 1) (see R19 R21)
        bc      = coef_live_reg[band_idx];
        k1q     = $signed({4'h0, bc.k1_mant, 3'h0} >> bc.k1_exp);
        k2q     = $signed({4'h0, bc.k2_mant, 10'h000} >> bc.k2_exp);
        kk1     = bc.k1_cfg ? (k1q - 18'sh04000) : (18'sh04000 - k1q);
        kk2     = bc.k2_cfg ? (k2q - 18'sh04000) : (18'sh04000 - k2q);
        a1_prod = 36'(kk2) * 36'(18'sh04000 + kk1);
        a1      = 18'(a1_prod >>> `AIDFE_Q_SHIFT);
        // All-pass section A(z), direct form (see R12)
        ap_acc  = 40'(kk1) * 40'(data_reg) + 40'(a1) * 40'(eq_x1[band_idx])
                - 40'(a1) * 40'(eq_y1[band_idx]) - 40'(kk1) * 40'(eq_y2[band_idx]);
        ap_sat  = sat16((ap_acc >>> `AIDFE_Q_SHIFT) + 40'(eq_x2[band_idx]));
        // (x+A)/2 + k0/32*(x-A)/2; seven-bit k0 keeps k0/32 below four, capping each band at 12 dB (see R13 R16)
        hsum    = 17'(data_reg) + 17'(ap_sat);
        hdiff   = 17'(data_reg) - 17'(ap_sat);
        h_acc   = ((40'(hsum) <<< 5) + 40'(hdiff) * $signed({33'h000000000, bc.k0})) >>> 6;
        band_out = sat16(bc.halve ? (h_acc >>> 1) : h_acc);   // see R17
        g_acc    = 32'(data_reg) * $signed({15'h0000, ramp_gain(gain_idx)});
        gain_out = off_mode ? 16'sh0000 : sat16(40'(g_acc >>> `AIDFE_Q_SHIFT));   // see R24
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dsp_st    <= D_IDLE;
            frame_reg <= '0;
            data_reg  <= 16'sh0000;
            band_idx  <= 3'h0;
        end else begin
            case (dsp_st)   // see R25
                D_IDLE: begin
                    if (sample_evt) begin
                        frame_reg <= rx_frame[active_port];   // see R2
                        dsp_st    <= D_MIX;
                    end
                end
                D_MIX: begin
                    data_reg <= mix_out;
                    dsp_st   <= D_HPF;
                end
                D_HPF: begin
                    data_reg <= hpf_out;
                    dsp_st   <= D_DEEM;
                end
                D_DEEM: begin
                    data_reg <= de_out;
                    band_idx <= 3'h0;
                    dsp_st   <= eq_bypass_reg ? D_GAIN : D_EQ;   // see R11
                end
                D_EQ: begin
                    data_reg <= band_out;   // see R15
                    band_idx <= band_idx + 3'h1;
                    if (band_idx == 3'(AIDFE_NUM_BANDS - 1))
                        dsp_st <= D_GAIN;
                end
                D_GAIN: begin
                    data_reg <= gain_out;
                    dsp_st   <= D_OUT;
                end
                D_OUT:   dsp_st <= D_IDLE;
                default: dsp_st <= D_IDLE;
            endcase
        end
    end

    // Filter memories; bypassed stages keep theirs frozen
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hp_x1_reg <= 16'sh0000;
            hp_y1_reg <= 16'sh0000;
            de_y1_reg <= 16'sh0000;
            for (int b = 0; b < AIDFE_NUM_BANDS; b++) begin
                eq_x1[b] <= 16'sh0000;
                eq_x2[b] <= 16'sh0000;
                eq_y1[b] <= 16'sh0000;
                eq_y2[b] <= 16'sh0000;
            end
        end else begin
            if (dsp_st == D_HPF && !hpf_off) begin
                hp_x1_reg <= data_reg;
                hp_y1_reg <= hpf_out;
            end
            if (dsp_st == D_DEEM && deemph_rate_choice != 2'h0)
                de_y1_reg <= de_out;
            if (dsp_st == D_EQ) begin
                eq_x1[band_idx] <= data_reg;
                eq_x2[band_idx] <= eq_x1[band_idx];
                eq_y1[band_idx] <= ap_sat;
                eq_y2[band_idx] <= eq_y1[band_idx];
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            audio_out       <= 16'h0000;
            audio_out_valid <= 1'b0;
        end else begin
            audio_out_valid <= (dsp_st == D_OUT);
            if (dsp_st == D_OUT)
                audio_out <= data_reg;
        end
    end

    // Port-change sequencer steps once per output sample (see R3)
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mute_st          <= M_RUN;
            gain_idx         <= `AIDFE_MUTE_STEPS;
            active_port      <= 1'b0;
            off_mode         <= 1'b0;
            soft_mute_active <= 1'b0;
        end else if (dsp_st == D_OUT) begin
            case (mute_st)
                M_RUN: begin
                    if (insel_reg != active_port) begin
                        mute_st          <= M_DOWN;
                        soft_mute_active <= 1'b1;
                    end
                end
                M_DOWN: begin
                    gain_idx <= gain_idx - 8'h01;   // see R24
                    if (gain_idx == 8'h01) begin
                        mute_st  <= M_SWAP;
                        off_mode <= 1'b1;
                    end
                end
                M_SWAP: begin
                    active_port <= insel_reg;   // see R3
                    off_mode    <= 1'b0;
                    mute_st     <= M_UP;
                end
                M_UP: begin
                    gain_idx <= gain_idx + 8'h01;
                    if (gain_idx == `AIDFE_MUTE_STEPS - 8'h01) begin
                        mute_st          <= M_RUN;
                        soft_mute_active <= 1'b0;
                    end
                end
                default: mute_st <= M_RUN;
            endcase
        end
    end

    property p_swap_only_when_off;
        @(posedge clock) disable iff (sys_rst)
        $changed(active_port) |-> $past(mute_st) == M_SWAP && $past(off_mode);
    endproperty
    a_swap_only_when_off: assert property (p_swap_only_when_off) else $error("port swap outside off mode"); // see R3

    property p_mute_starts_on_change;
        @(posedge clock) disable iff (sys_rst)
        (dsp_st == D_OUT && mute_st == M_RUN && insel_reg != active_port) |=> mute_st == M_DOWN && soft_mute_active;
    endproperty
    a_mute_starts_on_change: assert property (p_mute_starts_on_change) else $error("soft mute not started"); // see R3

    property p_full_gain_in_run;
        @(posedge clock) disable iff (sys_rst)
        mute_st == M_RUN |-> gain_idx == 8'h80 && !off_mode;
    endproperty
    a_full_gain_in_run: assert property (p_full_gain_in_run) else $error("gain not unity while running"); // see R24

    property p_ramp_step;
        @(posedge clock) disable iff (sys_rst)
        (mute_st == M_DOWN && $changed(gain_idx)) |-> gain_idx == $past(gain_idx) - 8'h01;
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp step wrong"); // see R24

    property p_commit_on_word2;
        @(posedge clock) disable iff (sys_rst)
        (coef_live_reg[0] != $past(coef_live_reg[0])) |-> $past(eq_w2_wr) && $past(eq_band) == 3'h0;
    endproperty
    a_commit_on_word2: assert property (p_commit_on_word2) else $error("band changed without word two"); // see R26

    property p_hpf_write;
        @(posedge clock) disable iff (sys_rst)
        (reg_wr_en && reg_addr == 8'h11) |=> highpass_coef_setting == $past(reg_wr_data[8:0]);
    endproperty
    a_hpf_write: assert property (p_hpf_write) else $error("high-pass setting not stored"); // see R7

    property p_hpf_bypass;
        @(posedge clock) disable iff (sys_rst)
        (dsp_st == D_HPF && hpf_off) |=> data_reg == $past(data_reg) && dsp_st == D_DEEM;
    endproperty
    a_hpf_bypass: assert property (p_hpf_bypass) else $error("high-pass not bypassed"); // see R8

    property p_deemph_off;
        @(posedge clock) disable iff (sys_rst)
        (dsp_st == D_DEEM && deemph_rate_choice == 2'h0) |=> data_reg == $past(data_reg);
    endproperty
    a_deemph_off: assert property (p_deemph_off) else $error("de-emphasis active when off"); // see R10

    property p_eq_bypass;
        @(posedge clock) disable iff (sys_rst)
        (dsp_st == D_DEEM && eq_bypass_reg) |=> dsp_st == D_GAIN;
    endproperty
    a_eq_bypass: assert property (p_eq_bypass) else $error("equalizer not bypassed"); // see R11

    property p_one_out_per_in;
        @(posedge clock) disable iff (sys_rst)
        (dsp_st == D_IDLE && sample_evt) |-> ##[4:12] audio_out_valid;
    endproperty
    a_one_out_per_in: assert property (p_one_out_per_in) else $error("no output for input sample"); // see R25

    property p_five_bands;
        @(posedge clock) disable iff (sys_rst)
        (dsp_st == D_DEEM && !eq_bypass_reg) |=> (dsp_st == D_EQ) [*5] ##1 dsp_st == D_GAIN;
    endproperty
    a_five_bands: assert property (p_five_bands) else $error("band sequence length wrong"); // see R15

endmodule : aidfe_top
`default_nettype wire

// ==== aidfe_regs.svh ====
`ifndef AIDFE_REGS_SVH
`define AIDFE_REGS_SVH

`define AIDFE_DEV_CTRL_OFS   8'h00
`define AIDFE_SP1_CTRL_OFS   8'h01
`define AIDFE_SP2_CTRL_OFS   8'h03
`define AIDFE_BYPASS_OFS     8'h10
`define AIDFE_HPF_OFS        8'h11
`define AIDFE_DEEMPH_OFS     8'h12
`define AIDFE_EQ_BASE_OFS    8'h20
`define AIDFE_EQ_WORDS       8'h0A

`define AIDFE_INSEL_BIT      0
`define AIDFE_HPSKIP_BIT     0
`define AIDFE_EQBYP_BIT      1

`define AIDFE_SP_CTRL_RST    16'h0002
`define AIDFE_BYPASS_RST     16'h0002
`define AIDFE_HPF_RST        9'h000
`define AIDFE_DEEMPH_RST     2'h0

`define AIDFE_MUTE_STEPS     8'h80
`define AIDFE_HPF_SHIFT      12
`define AIDFE_Q_SHIFT        14
`define AIDFE_DEEMPH_A32     16'h3F66
`define AIDFE_DEEMPH_A44     16'h323E
`define AIDFE_DEEMPH_A48     16'h2F11

`endif

// ==== aidfe_pkg.sv ====
package aidfe_pkg;

    localparam int AIDFE_NUM_BANDS = 5;

    typedef struct packed {
        logic        k1_cfg;
        logic [10:0] k1_mant;
        logic [3:0]  k1_exp;
        logic        k2_cfg;
        logic [3:0]  k2_mant;
        logic [2:0]  k2_exp;
        logic [6:0]  k0;
        logic        halve;
    } aidfe_band_coef_t;

    typedef struct packed {
        logic signed [15:0] left;
        logic signed [15:0] right;
    } aidfe_frame_t;

    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_MIX  = 3'b001,
        D_HPF  = 3'b011,
        D_DEEM = 3'b010,
        D_EQ   = 3'b110,
        D_GAIN = 3'b111,
        D_OUT  = 3'b101
    } aidfe_dsp_state_t;

    typedef enum logic [1:0] {
        M_RUN  = 2'b00,
        M_DOWN = 2'b01,
        M_SWAP = 2'b11,
        M_UP   = 2'b10
    } aidfe_mute_state_t;

endpackage : aidfe_pkg

// ==== aidfe_serial_src.sv ====
`timescale 1ns/100ps
`default_nettype none
module aidfe_serial_src (
    output var logic bclk,
    output var logic fsync,
    output var logic sdata
);
    initial begin
        bclk = 1'b0;
        fsync = 1'b0;
        sdata = 1'b0;
    end
    // Clock stands still between frames; a released data line shows the inverse, not the last bit
    task automatic send(input logic [31:0] word);
        for (int i = 31; i >= -1; i--) begin
            fsync = (i == 31);
            sdata = (i >= 0) ? word[i] : ~word[0];
            #32 bclk = 1'b1;
            #32 bclk = 1'b0;
        end
    endtask : send
endmodule : aidfe_serial_src
`default_nettype wire

// ==== tb_audio_input_dsp_front_end.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_audio_input_dsp_front_end;
    logic        clock;
    logic        sys_rst;
    wire  [1:0]  bit_clk;
    wire  [1:0]  frame_sync_pin;
    wire  [1:0]  serial_data_pin;
    logic        reg_wr_en;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wr_data;
    logic [15:0] reg_rd_data;
    logic [15:0] audio_out;
    logic        audio_out_valid;
    logic        off_mode;
    logic        active_port;
    logic        soft_mute_active;
    int          fail_count;
    int          n_checks;
    int          n;
    int          k;
    logic [15:0] lv;
    logic [15:0] rv;
    logic        saw_off;

    aidfe_serial_src s0 (.bclk(bit_clk[0]), .fsync(frame_sync_pin[0]), .sdata(serial_data_pin[0]));
    aidfe_serial_src s1 (.bclk(bit_clk[1]), .fsync(frame_sync_pin[1]), .sdata(serial_data_pin[1]));
    aidfe_top dut (.clock(clock), .sys_rst(sys_rst), .bit_clk(bit_clk), .frame_sync_pin(frame_sync_pin),
        .serial_data_pin(serial_data_pin), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .audio_out(audio_out),
        .audio_out_valid(audio_out_valid), .off_mode(off_mode), .active_port(active_port),
        .soft_mute_active(soft_mute_active));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) if (off_mode === 1'b1) saw_off <= 1'b1;

    function automatic logic [15:0] mix(input logic [1:0] m, input logic [15:0] l, input logic [15:0] r);
        logic [16:0] s;
        s = {l[15], l} + {r[15], r};
        return (m == 2'h0) ? l : (m == 2'h1) ? r : s[16:1];
    endfunction : mix

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clock);
        reg_wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_addr <= a;
        repeat (2) @(posedge clock);
        #1 chk("reg", e, reg_rd_data);
    endtask : rd

    // Waits for the one-cycle output strobe; a missing strobe ends the run
    task automatic frame(input logic [15:0] l, input logic [15:0] r, input logic [15:0] e, input logic c);
        if (active_port === 1'b1) s1.send({l, r});
        else s0.send({l, r});
        for (n = 0; n < 40 && audio_out_valid !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        if (n == 40) begin
            fail_count++;
            end_sim();
        end
        if (c) chk("audio", e, audio_out);
    endtask : frame

    initial begin
        sys_rst = 1'b1;
        reg_wr_en = 1'b0;
        reg_addr = 8'h00;
        reg_wr_data = 16'h0000;
        fail_count = 0;
        n_checks = 0;
        saw_off = 1'b0;
        void'($urandom(14));
        fork
            s0.send(32'h0);
            s1.send(32'h0);
        join_none
        repeat (8) @(posedge clock);
        #5 sys_rst = 1'b0;
        repeat (2) @(posedge clock);
        rd(8'h01, 16'h0002);
        rd(8'h03, 16'h0002);
        rd(8'h10, 16'h0002);
        rd(8'h12, 16'h0000);
        rd(8'h05, 16'h0000);
        wr(8'h11, 16'hFFFF);
        rd(8'h11, 16'h01FF);
        for (int i = 0; i < 4; i++) begin
            wr(8'h12, 16'(i));
            rd(8'h12, 16'(i));
        end
        wr(8'h12, 16'h0000);
        wr(8'h11, 16'h0000);
        wr(8'h20, 16'h9A5B);
        rd(8'h20, 16'h0000);
        wr(8'h21, 16'h7A4D);
        rd(8'h20, 16'h9A5B);
        rd(8'h21, 16'h7A4D);
        $display("test registers done");
        wr(8'h10, 16'h0003);
        wr(8'h03, 16'h0001);
        for (int m = 0; m < 8; m++) begin
            lv = (m == 6) ? 16'h7FFF : 16'($urandom);
            rv = (m == 6) ? 16'h7FFF : 16'($urandom);
            wr(8'h01, 16'(m % 4));
            frame(lv, rv, mix(2'(m % 4), lv, rv), 1'b1);
        end
        wr(8'h10, 16'h0002);
        frame(lv, rv, mix(2'h2, lv, rv), 1'b1);
        $display("test mix done");
        wr(8'h11, 16'h01FF);
        frame(16'h1000, 16'h1000, 16'h1000, 1'b1);
        frame(16'h1000, 16'h1000, 16'h0E01, 1'b1);
        wr(8'h11, 16'h0000);
        wr(8'h12, 16'h0001);
        frame(16'h4000, 16'h4000, 16'h1FB3, 1'b1);
        wr(8'h12, 16'h0000);
        // Unity k0 makes every band pass x; halving on A and B leaves x/4
        for (int b = 0; b < 5; b++) begin
            wr(8'(8'h20 + 2 * b), 16'h0000);
            wr(8'(8'h21 + 2 * b), (b < 2) ? 16'h0041 : 16'h0040);
        end
        wr(8'h10, 16'h0001);
        lv = 16'($urandom);
        rv = 16'($urandom);
        frame(lv, rv, 16'($signed(mix(2'h2, lv, rv)) >>> 2), 1'b1);
        wr(8'h10, 16'h0002);
        $display("test filters done");
        wr(8'h00, 16'h0001);
        for (k = 0; k < 300 && !(active_port === 1'b1 && soft_mute_active === 1'b0); k++) begin
            frame(lv, rv, 16'h0000, 1'b0);
        end
        chk("off", 16'h0001, {15'h0, saw_off});
        chk("ramp", 16'h0001, {15'h0, k >= 256 && k < 300});
        rd(8'h00, 16'h0003);
        frame(lv, rv, mix(2'h1, lv, rv), 1'b1);
        $display("test port swap done");
        end_sim();
    end
endmodule : tb_audio_input_dsp_front_end
`default_nettype wire
